// ### sspr_defs.svh
// Constants for the start-stop five-level print receiver
// What this block does
// - Line current present means marking; no current means spacing, every interval.
// - Each frame carries exactly five information intervals forming one five-bit code.
// - Frame starts with a spacing start interval; its leading edge times sampling.
// - Frame ends with a marking stop interval, sampled only at its centre before the next start.
// - Standard stop lasts 1.42 units, so the frame is 7.42 units.
// - Alternative stop of one unit gives a 7.0 unit frame; both accepted.
// - Each printed graphic advances the print position one character right.
// - Certain non-printing function codes suppress that frame's position advance.
// - Line-advance code feeds one or two lines per setting; local input also.
// - Each code does print-advance, space (advancing only for the space code), tabulate, or return to margin.
// - Special function fires on one code or an ordered multi-code sequence.
// - Codes reused for special functions still print normally when no match.
// - Ribbon steps after each print; direction flips on spool-empty indication.
// - All-marking code 12345 selects letters case for following codes.
// - Code 12-45 selects figures case for following codes.
`ifndef SSPR_DEFS_SVH
`define SSPR_DEFS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define SSPR_CLK_HZ        40000000
`define SSPR_BAUD_DEF      45
`define SSPR_UNIT_CYC(b)   (`SSPR_CLK_HZ / (b))
`define SSPR_STOP_STD_X100 142
`define SSPR_STOP_ALT_X100 100

// ----------------------------------------
// Codes, interval 1 in bit 0
// ----------------------------------------
`define SSPR_CODE_LTRS     5'h1F
`define SSPR_CODE_FIGS     5'h1B
`define SSPR_CODE_CR       5'h08
`define SSPR_CODE_LF       5'h02
`define SSPR_CODE_SPACE    5'h04
`define SSPR_CODE_BLANK    5'h00
`define SSPR_CODE_TAB_DEF  5'h00
`define SSPR_SEQ_LEN       2

`endif

// ### sspr_pkg.sv
// Types for the start-stop five-level print receiver
package sspr_pkg;
  typedef enum logic [2:0] {
    SSPR_IDLE  = 3'b000,
    SSPR_START = 3'b001,
    SSPR_DATA  = 3'b010,
    SSPR_STOP  = 3'b011,
    SSPR_WAIT  = 3'b100
  } sspr_rx_e;
  typedef enum logic [1:0] {
    SSPR_ACT_PRINT = 2'b00,
    SSPR_ACT_SPACE = 2'b01,
    SSPR_ACT_TAB   = 2'b10,
    SSPR_ACT_CR    = 2'b11
  } sspr_act_e;
endpackage

// ### sspr_buf2.sv
// Two-entry buffer between frame receiver and decoder
`timescale 1ns/1ps
module sspr_buf2 #(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             nrst,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  logic [WIDTH-1:0] mem_reg [2];
  logic             wrPtr_reg;
  logic             rdPtr_reg;
  logic [1:0]       count_reg;
  wire              doPush = inValid && inReady;
  wire              doPop  = outValid && outReady;

  assign inReady  = (count_reg != 2'd2);
  assign outValid = (count_reg != 2'd0);
  assign outData  = mem_reg[rdPtr_reg];

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      wrPtr_reg  <= 1'b0;
      rdPtr_reg  <= 1'b0;
      count_reg  <= 2'd0;
    end else begin
      if (doPush) begin
        mem_reg[wrPtr_reg] <= inData;
        wrPtr_reg          <= ~wrPtr_reg;
      end
      if (doPop)
        rdPtr_reg <= ~rdPtr_reg;
      count_reg <= count_reg + {1'b0, doPush} - {1'b0, doPop};
    end
  end
endmodule

// ### sspr_receiver.sv
// Start-stop five-level print receiver: frame capture, case shift, actions
`timescale 1ns/1ps
`include "sspr_defs.svh"
module sspr_receiver #(
  parameter int       BAUD     = `SSPR_BAUD_DEF,
  parameter int       UNIT_CYC = `SSPR_UNIT_CYC(BAUD),
  parameter int       SEQ_LEN  = `SSPR_SEQ_LEN,
  parameter logic [9:0] SEQ_CODES = 10'h0_0C2
) (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  // Signal line, high while loop current flows
  input  wire logic                   lineCurrent,
  // Configuration and local controls
  input  wire logic                   stopShort,
  input  wire logic                   doubleFeed,
  input  wire logic                   tabFitted,
  input  wire logic                   localLineFeed,
  input  wire logic                   spoolEmpty,
  // Mechanism command stream
  output logic                        actValid,
  input  wire logic                   actReady,
  output sspr_pkg::sspr_act_e         actKind,
  output logic                        [4:0] actCode,
  output logic                        actFigures,
  output logic                        actAdvance,
  // Auxiliary mechanism strobes and status levels
  output logic                        lineFeedPulse,
  output logic                        [1:0] lineFeedCount,
  output logic                        ribbonStep,
  output logic                        ribbonReverse,
  output logic                        specialFunc,
  output logic                        figuresCase,
  output logic                        frameError
);
  import sspr_pkg::*;

  // ----------------------------------------
  // Line synchroniser
  // ----------------------------------------
  logic lineMeta_reg;
  logic lineSync_reg;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lineMeta_reg <= 1'b1;
      lineSync_reg <= 1'b1;
    end else begin
      lineMeta_reg <= lineCurrent;
      lineSync_reg <= lineMeta_reg;
    end
  end
  wire marking = lineSync_reg;

  // ----------------------------------------
  // Frame receiver
  // ----------------------------------------
  localparam int CW       = 32;
  localparam int HALF_CYC = UNIT_CYC / 2;
  // Stop length is checked only to its centre, so both patterns pass
  localparam int STOP_STD = (UNIT_CYC * `SSPR_STOP_STD_X100) / 100;
  localparam int STOP_ALT = (UNIT_CYC * `SSPR_STOP_ALT_X100) / 100;

  sspr_rx_e        rxState_reg;
  logic [CW-1:0]   timer_reg;
  logic [2:0]      bitIdx_reg;
  logic [4:0]      shift_reg;
  logic            frameDone_reg;
  logic            frameError_reg;
  logic            pushValid;
  logic            pushReady;

  wire [CW-1:0] stopCyc   = stopShort ? CW'(STOP_ALT) : CW'(STOP_STD);
  wire          timerDone = (timer_reg == '0);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rxState_reg    <= SSPR_IDLE;
      timer_reg      <= '0;
      bitIdx_reg     <= 3'd0;
      shift_reg      <= 5'h0_0;
      frameDone_reg  <= 1'b0;
      frameError_reg <= 1'b0;
    end else begin
      frameDone_reg  <= 1'b0;
      frameError_reg <= 1'b0;
      if (!timerDone)
        timer_reg <= timer_reg - CW'(1);
      unique case (rxState_reg)
        SSPR_IDLE: if (!marking) begin
          rxState_reg <= SSPR_START;
          timer_reg   <= CW'(HALF_CYC - 1);
        end
        SSPR_START: if (timerDone) begin
          if (marking) begin
            rxState_reg <= SSPR_IDLE; // Glitch, not a start interval
          end else begin
            rxState_reg <= SSPR_DATA;
            bitIdx_reg  <= 3'd0;
            timer_reg   <= CW'(UNIT_CYC - 1);
          end
        end
        SSPR_DATA: if (timerDone) begin
          shift_reg <= {marking, shift_reg[4:1]};
          timer_reg <= CW'(UNIT_CYC - 1);
          if (bitIdx_reg == 3'd4) begin
            rxState_reg <= SSPR_STOP;
            timer_reg   <= (stopCyc >> 1) + CW'(HALF_CYC) - CW'(1);
          end else
            bitIdx_reg <= bitIdx_reg + 3'd1;
        end
        SSPR_STOP: if (timerDone) begin
          if (marking) begin
            frameDone_reg <= 1'b1;
            rxState_reg   <= SSPR_IDLE;
          end else begin
            frameError_reg <= 1'b1;
            rxState_reg    <= SSPR_WAIT;
          end
        end
        SSPR_WAIT: if (marking)
          rxState_reg <= SSPR_IDLE;
        default: rxState_reg <= SSPR_IDLE;
      endcase
    end
  end
  assign pushValid  = frameDone_reg;
  assign frameError = frameError_reg;

  // ----------------------------------------
  // Buffer
  // ----------------------------------------
  logic       codeValid;
  logic       codeReady;
  logic [4:0] code;
  // A single-cycle push; two slots cover a decoder stalled for one frame
  sspr_buf2 #(.WIDTH(5)) uBuf (
    .mclk     (mclk),
    .nrst     (nrst),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .inData   (shift_reg),
    .outValid (codeValid),
    .outReady (codeReady),
    .outData  (code)
  );

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic       figures_reg;
  logic [4:0] seqHist_reg;
  logic       ribbonDir_reg;
  logic       spoolPrev_reg;
  logic       outValid_reg;
  sspr_act_e  outKind_reg;
  logic [4:0] outCode_reg;
  logic       outFig_reg;
  logic       outAdv_reg;
  logic       lfPulse_reg;
  logic [1:0] lfCount_reg;
  logic       ribStep_reg;
  logic       special_reg;

  wire take      = codeValid && codeReady;
  assign codeReady = !outValid_reg || actReady;
  wire isLtrs    = (code == `SSPR_CODE_LTRS);
  wire isFigs    = (code == `SSPR_CODE_FIGS);
  wire isCr      = (code == `SSPR_CODE_CR);
  wire isLf      = (code == `SSPR_CODE_LF);
  wire isSpace   = (code == `SSPR_CODE_SPACE);
  wire isTab     = tabFitted && figures_reg && (code == `SSPR_CODE_TAB_DEF);
  wire singleHit = (code == `SSPR_CODE_BLANK);
  wire seqHit    = (SEQ_LEN > 1) && (seqHist_reg == SEQ_CODES[4:0])
                   && (code == SEQ_CODES[9:5]);
  wire nonPrint  = isLtrs || isFigs || isCr || isLf || singleHit;
  wire printable = !nonPrint && !isSpace && !isTab && !seqHit;
  wire spoolRise = spoolEmpty && !spoolPrev_reg;
  wire anyFeed   = (take && isLf) || localLineFeed;

  sspr_act_e kindNext;
  assign kindNext = isCr ? SSPR_ACT_CR : isTab ? SSPR_ACT_TAB :
                    printable ? SSPR_ACT_PRINT : SSPR_ACT_SPACE;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      figures_reg   <= 1'b0;
      seqHist_reg   <= 5'h0_0;
      ribbonDir_reg <= 1'b0;
      spoolPrev_reg <= 1'b0;
      outValid_reg  <= 1'b0;
      outKind_reg   <= SSPR_ACT_SPACE;
      outCode_reg   <= 5'h0_0;
      outFig_reg    <= 1'b0;
      outAdv_reg    <= 1'b0;
      lfPulse_reg   <= 1'b0;
      lfCount_reg   <= 2'd0;
      ribStep_reg   <= 1'b0;
      special_reg   <= 1'b0;
    end else begin
      spoolPrev_reg <= spoolEmpty;
      if (spoolRise)
        ribbonDir_reg <= ~ribbonDir_reg;
      lfPulse_reg <= anyFeed;
      if (anyFeed)
        lfCount_reg <= doubleFeed ? 2'd2 : 2'd1;
      ribStep_reg <= take && printable;
      special_reg <= take && (seqHit || singleHit);
      if (actReady)
        outValid_reg <= 1'b0;
      if (take) begin
        if (isLtrs)
          figures_reg <= 1'b0;
        else if (isFigs)
          figures_reg <= 1'b1;
        seqHist_reg  <= code;
        outValid_reg <= 1'b1;
        outKind_reg  <= kindNext;
        outCode_reg  <= code;
        outFig_reg   <= figures_reg;
        outAdv_reg   <= !nonPrint && !isTab && !seqHit;
      end
    end
  end

  assign actValid      = outValid_reg;
  assign actKind       = outKind_reg;
  assign actCode       = outCode_reg;
  assign actFigures    = outFig_reg;
  assign actAdvance    = outAdv_reg;
  assign lineFeedPulse = lfPulse_reg;
  assign lineFeedCount = lfCount_reg;
  assign ribbonStep    = ribStep_reg;
  assign ribbonReverse = ribbonDir_reg;
  assign specialFunc   = special_reg;
  assign figuresCase   = figures_reg;
endmodule

// ### sspr_line_tx.sv
// Line transmitter model driving the receiver's signal line
`timescale 1ns/1ps
module sspr_line_tx #(
  parameter int UNIT = 16
) (
  // Clock
  input  wire logic mclk,
  // Signal line, high while loop current flows
  output logic      lineCurrent
);
  // Idle line carries current, so the receiver sees marking between frames
  initial lineCurrent = 1'b1;

  task automatic hold(input logic lvl, input int n);
    lineCurrent <= lvl;
    repeat (n) @(posedge mclk);
  endtask

  task automatic send(input logic [4:0] code, input logic shortStop, input logic badStop);
    hold(1'b0, UNIT);
    for (int i = 0; i < 5; i++)
      hold(code[i], UNIT);
    hold(!badStop, shortStop ? UNIT : UNIT * 142 / 100);
    if (badStop)
      hold(1'b1, 2 * UNIT);
  endtask

  // Start pulse too short to be a real frame
  task automatic glitch(input int n);
    hold(1'b0, n);
    hold(1'b1, 2 * UNIT);
  endtask
endmodule

// ### sspr_monitor.sv
// Port checker for the print receiver
`timescale 1ns/1ps
`include "sspr_defs.svh"
module sspr_monitor (
  // Clock and reset
  input wire logic                mclk,
  input wire logic                nrst,
  // Controls
  input wire logic                actReady,
  input wire logic                doubleFeed,
  input wire logic                tabFitted,
  input wire logic                spoolEmpty,
  // Outputs watched
  input wire logic                actValid,
  input wire sspr_pkg::sspr_act_e actKind,
  input wire logic [4:0]          actCode,
  input wire logic                actAdvance,
  input wire logic                lineFeedPulse,
  input wire logic [1:0]          lineFeedCount,
  input wire logic                ribbonStep,
  input wire logic                ribbonReverse,
  input wire logic                frameError
);
  import sspr_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_stall;
    actValid && !actReady;
  endsequence
  a_offer_holds: assert property (s_stall |=> actValid && $stable(actCode) && $stable(actKind))
    else $error("action changed while stalled");
  a_rib_print: assert property (ribbonStep |-> actValid && actKind == SSPR_ACT_PRINT)
    else $error("ribbon step without print");
  // Back-to-back prints step on adjacent cycles; a step must come with a fresh offer
  a_rib_single: assert property (ribbonStep |-> !$past(actValid) || $past(actReady))
    else $error("ribbon stepped twice");
  a_print_adv: assert property (ribbonStep |-> actAdvance)
    else $error("print without advance");
  a_feed_count: assert property (lineFeedPulse |-> lineFeedCount == (doubleFeed ? 2'd2 : 2'd1))
    else $error("wrong feed count");
  a_feed_single: assert property (lineFeedPulse |=> !lineFeedPulse)
    else $error("feed pulse too long");
  a_cr_noadv: assert property (actValid && actKind == SSPR_ACT_CR |-> !actAdvance)
    else $error("return advanced");
  a_space_adv: assert property (actValid && actKind == SSPR_ACT_SPACE && actCode == `SSPR_CODE_SPACE |-> actAdvance)
    else $error("space did not advance");
  a_tab_fitted: assert property (actValid && actKind == SSPR_ACT_TAB |-> tabFitted)
    else $error("tab while not fitted");
  a_spool_flip: assert property ($rose(spoolEmpty) |-> ##[1:2] $changed(ribbonReverse))
    else $error("ribbon did not reverse");
  a_err_single: assert property (frameError |=> !frameError)
    else $error("frame error too long");
endmodule

bind sspr_receiver sspr_monitor u_mon (.mclk, .nrst, .actReady, .doubleFeed, .tabFitted,
  .spoolEmpty, .actValid, .actKind, .actCode, .actAdvance, .lineFeedPulse, .lineFeedCount,
  .ribbonStep, .ribbonReverse, .frameError);

// ### sspr_receiver_tb.sv
// Self-checking bench for the print receiver
`timescale 1ns/1ps
`include "sspr_defs.svh"
module sspr_receiver_tb;
  import sspr_pkg::*;
  localparam int UNIT = 16;
  logic mclk, nrst, stopShort, doubleFeed, tabFitted, localLineFeed, spoolEmpty, actReady;
  logic actValid, actFigures, actAdvance, lineFeedPulse, ribbonStep, ribbonReverse;
  logic specialFunc, figuresCase, frameError;
  logic [4:0] actCode;
  logic [1:0] lineFeedCount;
  sspr_act_e actKind;
  wire logic lineCurrent;
  logic [8:0] got[$];
  int nRib = 0, nLf = 0, nSpec = 0, nErr = 0, err_total = 0, checks = 0;

  sspr_line_tx #(.UNIT(UNIT)) tx (.mclk(mclk), .lineCurrent(lineCurrent));
  sspr_receiver #(.UNIT_CYC(UNIT)) DUT (.mclk(mclk), .nrst(nrst), .lineCurrent(lineCurrent),
    .stopShort(stopShort), .doubleFeed(doubleFeed), .tabFitted(tabFitted),
    .localLineFeed(localLineFeed), .spoolEmpty(spoolEmpty), .actValid(actValid),
    .actReady(actReady), .actKind(actKind), .actCode(actCode), .actFigures(actFigures),
    .actAdvance(actAdvance), .lineFeedPulse(lineFeedPulse), .lineFeedCount(lineFeedCount),
    .ribbonStep(ribbonStep), .ribbonReverse(ribbonReverse), .specialFunc(specialFunc),
    .figuresCase(figuresCase), .frameError(frameError));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Taken actions as {figures, advance, kind, code}, and pulse counts
  always @(posedge mclk) begin
    if (actValid === 1'b1 && actReady === 1'b1) got.push_back({actFigures, actAdvance, actKind, actCode});
    if (ribbonStep === 1'b1) nRib++;
    if (lineFeedPulse === 1'b1) nLf++;
    if (specialFunc === 1'b1) nSpec++;
    if (frameError === 1'b1) nErr++;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One frame, then time for the action to come out
  task automatic f(input logic [4:0] c);
    tx.send(c, stopShort, 1'b0);
    repeat (8) @(posedge mclk);
  endtask

  task automatic s_print();
    tx.send(5'h03, 1'b0, 1'b0);
    stopShort <= 1'b1;
    @(posedge mclk);
    f(5'h19);
    stopShort <= 1'b0;
    chk(got[0], {2'b01, SSPR_ACT_PRINT, 5'h03});
    chk(got[1], {2'b01, SSPR_ACT_PRINT, 5'h19});
    chk(nRib, 2);
  endtask

  task automatic s_case();
    tabFitted <= 1'b1;
    f(`SSPR_CODE_FIGS);
    chk(got[$][7], 0);
    f(5'h03);
    chk(got[$], {2'b11, SSPR_ACT_PRINT, 5'h03});
    f(`SSPR_CODE_BLANK);
    chk(got[$][6:5], SSPR_ACT_TAB);
    f(`SSPR_CODE_LTRS);
    tabFitted <= 1'b0;
    f(5'h03);
    chk({figuresCase, got[$]}, {3'b001, SSPR_ACT_PRINT, 5'h03});
  endtask

  task automatic s_func();
    doubleFeed <= 1'b1;
    f(`SSPR_CODE_CR);
    chk(got[$][7:5], {1'b0, SSPR_ACT_CR});
    f(`SSPR_CODE_SPACE);
    chk(got[$][7:0], {1'b1, SSPR_ACT_SPACE, `SSPR_CODE_SPACE});
    f(`SSPR_CODE_LF);
    chk({nLf, lineFeedCount}, {32'd1, 2'd2});
    doubleFeed <= 1'b0;
    localLineFeed <= 1'b1;
    @(posedge mclk);
    localLineFeed <= 1'b0;
    repeat (4) @(posedge mclk);
    chk({nLf, lineFeedCount}, {32'd2, 2'd1});
  endtask

  task automatic s_special();
    nSpec = 0;
    f(`SSPR_CODE_BLANK);
    tx.send(`SSPR_CODE_LF, 1'b0, 1'b0);
    f(5'h06);
    chk(nSpec, 2);
    chk(got[$], {2'b00, SSPR_ACT_SPACE, 5'h06});
    f(5'h06);
    chk(got[$], {2'b01, SSPR_ACT_PRINT, 5'h06});
  endtask

  // Mechanism stalls while four frames arrive back to back
  task automatic s_stall();
    got.delete();
    actReady <= 1'b0;
    tx.send(5'h03, 1'b0, 1'b0);
    tx.send(5'h19, 1'b0, 1'b0);
    tx.send(5'h05, 1'b0, 1'b0);
    f(5'h07);
    chk({actValid, actCode}, {1'b1, 5'h03});
    actReady <= 1'b1;
    repeat (8) @(posedge mclk);
    chk({got[0][4:0], got[1][4:0], got.size() < 4}, {5'h03, 5'h19, 1'b1});
  endtask

  task automatic s_errors();
    logic r;
    got.delete();
    tx.send(5'h03, 1'b0, 1'b1);
    tx.glitch(UNIT / 4);
    chk(nErr, 1);
    chk(got.size(), 0);
    f(5'h19);
    chk(got[$], {2'b01, SSPR_ACT_PRINT, 5'h19});
    r = ribbonReverse;
    spoolEmpty <= 1'b1;
    @(posedge mclk);
    spoolEmpty <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(ribbonReverse, !r);
  endtask

  task automatic end_of_test();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    nrst = 1'b0;
    stopShort = 1'b0;
    doubleFeed = 1'b0;
    tabFitted = 1'b0;
    localLineFeed = 1'b0;
    spoolEmpty = 1'b0;
    actReady = 1'b1;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    chk({actValid, figuresCase}, 0);
    s_print();
    s_case();
    s_func();
    s_special();
    s_stall();
    s_errors();
    end_of_test();
  end

  // Whole run needs about 2560 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    end_of_test();
  end
endmodule
